// >>> rtl/pbs_port.sv
`timescale 1ns/1ps
module pbs_port (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_mode,
    input wire logic i_clk_qualify_n,
    input wire logic i_chip_select_one_n,
    input wire logic i_chip_select_two,
    input wire logic i_chip_select_three_n,
    input wire logic i_write_n,
    input wire logic i_advance_or_load,
    input wire logic [pbs_pkg::ADDR_W-1:pbs_pkg::BURST_W] i_addr,
    input wire logic i_burst_addr_bit_one,
    input wire logic i_burst_addr_bit_zero,
    input wire logic i_lane_write_sel_a_n,
    input wire logic i_lane_write_sel_b_n,
    input wire logic i_lane_write_sel_c_n,
    input wire logic i_lane_write_sel_d_n,
    input wire logic i_output_enable_n,
    input wire logic [pbs_pkg::DATA_W-1:0] i_data,
    input wire logic [pbs_pkg::LANES-1:0] i_parity_lines,
    output logic [pbs_pkg::DATA_W-1:0] o_data,
    output logic [pbs_pkg::DATA_W-1:0] o_data_oe_n,
    output logic [pbs_pkg::LANES-1:0] o_parity_lines,
    output logic [pbs_pkg::LANES-1:0] o_parity_lines_oe_n,
    output logic o_queue_ready
);
    localparam int AW = pbs_pkg::ADDR_W;
    localparam int BW = pbs_pkg::BURST_W;

    logic rst_meta_q;
    logic rst_n_q;
    logic en;
    logic selected;
    logic load;
    logic mode_q;
    logic started_q;
    pbs_pkg::pbs_op_e op_q;
    pbs_pkg::pbs_op_e op_d;
    logic [AW-1:BW] base_q;
    logic [AW-1:BW] base_d;
    logic [BW-1:0] start_q;
    logic [BW-1:0] start_d;
    logic [BW-1:0] cnt_q;
    logic [BW-1:0] cnt_d;
    logic [pbs_pkg::LANES-1:0] lanes_q;
    logic [pbs_pkg::LANES-1:0] lanes_d;
    logic [pbs_pkg::LANES-1:0] bw_n;
    logic [BW-1:0] low_addr;
    logic [AW-1:0] acc_addr;
    logic rd_valid_q;
    logic prev_desel_q;
    logic nxt_rd;
    pbs_pkg::pbs_op_e nxt_op;
    logic drive_d;
    pbs_pkg::pbs_word_s rd_word;
    pbs_pkg::pbs_wr_s push_word;
    pbs_pkg::pbs_wr_s drain_word;
    logic push;
    logic fifo_in_ready;
    logic drain_valid;
    logic drain_ready;
    logic mem_wr_en;
    logic [AW-1:0] mem_addr;
    logic [pbs_pkg::LEVEL_W-1:0] fifo_level;

    // Reset is released through two stages; everything else uses rst_n_q
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // The strap is caught once after release and then held
    always_ff @(posedge i_core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= pbs_pkg::MODE_RST;
            started_q <= 1'b0;
        end else if (!started_q) begin
            mode_q <= i_mode; // see RL16
            started_q <= 1'b1;
        end
    end

    assign en = ~i_clk_qualify_n; // see RL8
    assign selected = ~i_chip_select_one_n // see RL9
                    & i_chip_select_two // see RL10
                    & ~i_chip_select_three_n; // see RL17
    assign load = ~i_advance_or_load;
    assign bw_n = {i_lane_write_sel_d_n, i_lane_write_sel_c_n,
                   i_lane_write_sel_b_n, i_lane_write_sel_a_n};

    // Command decode; an advance continues the running burst's kind
    always_comb begin
        op_d = op_q;
        base_d = base_q;
        start_d = start_q;
        cnt_d = cnt_q;
        lanes_d = pbs_pkg::LANES_RST;
        if (load) begin
            if (selected) begin
                op_d = i_write_n ? pbs_pkg::OP_READ
                                 : pbs_pkg::OP_WRITE; // see RL3
                base_d = i_addr; // see RL6
                start_d = {i_burst_addr_bit_one, i_burst_addr_bit_zero};
                cnt_d = pbs_pkg::BURST_CNT_RST;
                if (!i_write_n) begin
                    lanes_d = ~bw_n; // see RL2
                end
            end else begin
                op_d = pbs_pkg::OP_DESEL; // see RL17
            end
        end else if (op_q != pbs_pkg::OP_DESEL) begin
            // Advancing while deselected does nothing; a load is needed
            cnt_d = cnt_q + pbs_pkg::BURST_STEP; // see RL5
            if (op_q == pbs_pkg::OP_WRITE) begin
                lanes_d = ~bw_n; // see RL2
            end
        end
    end

    // A high qualifier stretches the cycle: nothing moves, no deselect
    always_ff @(posedge i_core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            op_q <= pbs_pkg::OP_DESEL;
            base_q <= '0;
            start_q <= pbs_pkg::BURST_CNT_RST;
            cnt_q <= pbs_pkg::BURST_CNT_RST;
            lanes_q <= pbs_pkg::LANES_RST;
        end else if (en) begin // see RL15
            op_q <= op_d;
            base_q <= base_d;
            start_q <= start_d;
            cnt_q <= cnt_d;
            lanes_q <= lanes_d;
        end
    end

    // Burst sequence on the two low address bits
    assign low_addr = mode_q ? (start_q ^ cnt_q)
                             : (start_q + cnt_q); // see RL16
    assign acc_addr = {base_q, low_addr}; // see RL1

    // Read data register loads at the next qualified edge
    always_ff @(posedge i_core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_valid_q <= 1'b0;
            prev_desel_q <= 1'b1;
            o_data <= pbs_pkg::WORD_RST.data;
            o_parity_lines <= pbs_pkg::WORD_RST.parity;
        end else if (en) begin
            rd_valid_q <= op_q == pbs_pkg::OP_READ;
            prev_desel_q <= op_q == pbs_pkg::OP_DESEL;
            if (op_q == pbs_pkg::OP_READ) begin
                o_data <= rd_word.data; // see RL18
                o_parity_lines <= rd_word.parity;
            end
        end
    end

    // Write data is taken in the cycle after its command, then queued
    assign push = en && op_q == pbs_pkg::OP_WRITE && |lanes_q;
    assign push_word = '{addr: acc_addr, lane_en: lanes_q,
                         word: '{parity: i_parity_lines, data: i_data}};

    // Single-ported array: a read owns it, so queued writes must wait
    assign drain_ready = !(en && op_q == pbs_pkg::OP_READ);
    assign mem_wr_en = drain_valid & drain_ready;
    assign mem_addr = mem_wr_en ? drain_word.addr : acc_addr;

    pbs_fifo #(
        .WIDTH($bits(pbs_pkg::pbs_wr_s)),
        .DEPTH(pbs_pkg::FIFO_DEPTH)
    ) u_queue (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n_q),
        .i_in_valid(push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(push_word),
        .o_out_valid(drain_valid),
        .i_out_ready(drain_ready),
        .o_out_data(drain_word),
        .o_level(fifo_level)
    );

    pbs_mem u_mem (
        .i_clk(i_core_clk),
        .i_wr_en(mem_wr_en),
        .i_addr(mem_addr),
        .i_lane_en(drain_word.lane_en),
        .i_wr_word(drain_word.word),
        .o_rd_word(rd_word)
    );

    // Drive decision uses the values that the coming edge will hold
    assign nxt_op = en ? op_d : op_q;
    // Only a read's data phase drives; deselect phases never set this
    assign nxt_rd = en ? (op_q == pbs_pkg::OP_READ)
                       : rd_valid_q; // see RL14
    assign drive_d = nxt_rd
                   && nxt_op != pbs_pkg::OP_WRITE // see RL13
                   && !i_output_enable_n; // see RL11

    // Output enable is sampled, so it takes effect one clock late
    always_ff @(posedge i_core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_data_oe_n <= '1;
            o_parity_lines_oe_n <= '1;
        end else begin
            o_data_oe_n <= {pbs_pkg::DATA_W{!drive_d}}; // see RL12
            o_parity_lines_oe_n <= {pbs_pkg::LANES{!drive_d}};
        end
    end

    // Slack covers writes already in flight when ready drops
    always_ff @(posedge i_core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_queue_ready <= 1'b0;
        end else begin
            o_queue_ready <= fifo_level <= pbs_pkg::QUEUE_LIMIT;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n_q);

    sequence s_load_sel;
        en && load && selected;
    endsequence

    sequence s_read_phase;
        en && op_q == pbs_pkg::OP_READ;
    endsequence

    property p_freeze;
        !en |=> $stable(op_q) && $stable(cnt_q) && $stable(base_q)
            && $stable(o_data) && $stable(rd_valid_q);
    endproperty
    a_freeze: assert property (p_freeze) // see RL15
        else $error("state moved while qualifier high");

    property p_ignore_edge;
        !en && !i_write_n && op_q == pbs_pkg::OP_READ
            |=> op_q == pbs_pkg::OP_READ;
    endproperty
    a_ignore_edge: assert property (p_ignore_edge) // see RL8
        else $error("unqualified edge changed the operation");

    property p_write_cmd;
        s_load_sel ##0 !i_write_n
            |=> op_q == pbs_pkg::OP_WRITE && lanes_q == ~$past(bw_n);
    endproperty
    a_write_cmd: assert property (p_write_cmd) // see RL3
        else $error("write command not captured");

    property p_read_lanes;
        s_load_sel ##0 i_write_n
            |=> op_q == pbs_pkg::OP_READ
                && lanes_q == pbs_pkg::LANES_RST;
    endproperty
    a_read_lanes: assert property (p_read_lanes) // see RL2
        else $error("lane enabled without write strobe");

    property p_load;
        s_load_sel |=> base_q == $past(i_addr)
            && cnt_q == pbs_pkg::BURST_CNT_RST
            && start_q == $past({i_burst_addr_bit_one,
                                 i_burst_addr_bit_zero});
    endproperty
    a_load: assert property (p_load) // see RL6
        else $error("new address not loaded");

    property p_advance;
        en && !load && op_q != pbs_pkg::OP_DESEL
            |=> cnt_q == $past(cnt_q) + pbs_pkg::BURST_STEP
                && base_q == $past(base_q) && op_q == $past(op_q);
    endproperty
    a_advance: assert property (p_advance) // see RL5
        else $error("burst counter did not advance");

    property p_deselect;
        en && load && !selected |=> op_q == pbs_pkg::OP_DESEL;
    endproperty
    a_deselect: assert property (p_deselect) // see RL17
        else $error("device selected with bad select levels");

    property p_addr;
        s_read_phase |-> !mem_wr_en && mem_addr[AW-1:BW] == base_q
            && mem_addr[BW-1:0] == (mode_q ? (start_q ^ cnt_q)
                                           : (start_q + cnt_q));
    endproperty
    a_addr: assert property (p_addr) // see RL1
        else $error("read used the wrong location");

    property p_read_data;
        s_read_phase |=> rd_valid_q && o_data == $past(rd_word.data)
            && o_parity_lines == $past(rd_word.parity);
    endproperty
    a_read_data: assert property (p_read_data) // see RL18
        else $error("read data not presented one clock later");

    property p_write_mask;
        op_q == pbs_pkg::OP_WRITE |-> &o_data_oe_n
            && &o_parity_lines_oe_n;
    endproperty
    a_write_mask: assert property (p_write_mask) // see RL13
        else $error("pins driven during write data phase");

    property p_oe_high;
        i_output_enable_n |=> &o_data_oe_n && &o_parity_lines_oe_n;
    endproperty
    a_oe_high: assert property (p_oe_high) // see RL12
        else $error("pins driven with output enable high");

    property p_desel_quiet;
        prev_desel_q || op_q == pbs_pkg::OP_DESEL && !rd_valid_q
            |-> &o_data_oe_n;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet) // see RL14
        else $error("pins driven around a deselect");

    property p_drive_cause;
        !o_data_oe_n[0] |-> rd_valid_q && !$past(i_output_enable_n)
            && o_data_oe_n == '0;
    endproperty
    a_drive_cause: assert property (p_drive_cause) // see RL11
        else $error("drive without read data and output enable");

    property p_strap;
        started_q |=> $stable(mode_q);
    endproperty
    a_strap: assert property (p_strap) // see RL16
        else $error("burst order changed during operation");

    property p_push_room;
        push |-> fifo_in_ready;
    endproperty
    a_push_room: assert property (p_push_room) // see RL2
        else $error("write dropped by a full queue");
endmodule

// >>> rtl/pbs_pkg.sv
package pbs_pkg;
// Contract
// (RL1) Captured address selects one memory location
// (RL2) Active-low lane selects gate bytes with write
// (RL3) Write strobe sampled only in qualified cycles
// (RL4) Controller drives write strobe low to write
// (RL5) Advance high increments the burst counter
// (RL6) Advance low loads a fresh address
// (RL7) Controller loads fresh address after deselect
// (RL8) Qualifier high makes clock edges ignored
// (RL9) First select is active low, edge sampled
// (RL10) Second select is active high, edge sampled
// (RL11) Output enable low permits data drive
// (RL12) Output enable high keeps pins undriven; here OE is sampled, so pins release one clock after it rises
// (RL13) No drive during write data phase
// (RL14) No drive when deselected or just reselected
// (RL15) Qualifier high freezes state, never deselects
// (RL16) Strap high interleaved, low linear burst
// (RL17) Selected only for selects low, high, low
// (RL18) Read data one qualified clock later
    localparam int ADDR_W = 19;
    localparam int BURST_W = 2;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int FIFO_DEPTH = 16;
    localparam int QUEUE_SLACK = 4;
    localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;
    localparam logic [LEVEL_W-1:0] QUEUE_LIMIT =
        LEVEL_W'(FIFO_DEPTH - QUEUE_SLACK);
    localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [LANES-1:0] LANES_RST = 4'h0;
    localparam logic MODE_RST = 1'h1;

    typedef enum {OP_DESEL, OP_READ, OP_WRITE} pbs_op_e;

    typedef struct packed {
        logic [LANES-1:0] parity;
        logic [DATA_W-1:0] data;
    } pbs_word_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_en;
        pbs_word_s word;
    } pbs_wr_s;

    localparam pbs_word_s WORD_RST = '0;
endpackage

// >>> rtl/pbs_fifo.sv
`timescale 1ns/1ps
module pbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;
    logic push;
    logic pop;

    // Pointers carry one extra bit so full and empty stay distinct
    assign o_level = wr_ptr_q - rd_ptr_q;
    assign o_in_ready = o_level != (AW + 1)'(DEPTH);
    assign o_out_valid = o_level != '0;
    assign o_out_data = store[rd_ptr_q[AW-1:0]];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            store[wr_ptr_q[AW-1:0]] <= i_in_data;
        end
    end
endmodule

// >>> rtl/pbs_mem.sv
`timescale 1ns/1ps
module pbs_mem (
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [pbs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pbs_pkg::LANES-1:0] i_lane_en,
    input wire pbs_pkg::pbs_word_s i_wr_word,
    output pbs_pkg::pbs_word_s o_rd_word
);
    localparam int LW = pbs_pkg::LANE_W;

    wire [pbs_pkg::DATA_W-1:0] rd_data;
    wire [pbs_pkg::LANES-1:0] rd_parity;

    // One array per lane, each cell holding a byte and its parity bit
    for (genvar g = 0; g < pbs_pkg::LANES; g++) begin : g_lane
        logic [LW:0] cells [2**pbs_pkg::ADDR_W];

        always_ff @(posedge i_clk) begin
            if (i_wr_en && i_lane_en[g]) begin
                cells[i_addr] <= {i_wr_word.parity[g],
                                  i_wr_word.data[g*LW +: LW]};
            end
        end

        assign rd_data[g*LW +: LW] = cells[i_addr][LW-1:0];
        assign rd_parity[g] = cells[i_addr][LW];
    end

    assign o_rd_word = {rd_parity, rd_data};
endmodule

// >>> sim/pbs_host.sv
`timescale 1ns/1ps
module pbs_host (
    input wire logic i_clk,
    output logic o_qual_n,
    output logic [2:0] o_sel,
    output logic o_write_n,
    output logic o_adv,
    output logic [pbs_pkg::ADDR_W-1:0] o_addr,
    output logic [3:0] o_lanes_n,
    output pbs_pkg::pbs_word_s o_word
);
    pbs_pkg::pbs_word_s pend;
    logic pend_v;
    logic in_wr;
    initial begin
        o_qual_n = 1'b0;
        o_sel = 3'h5;
        o_write_n = 1'b1;
        o_adv = 1'b0;
        o_addr = '0;
        o_lanes_n = 4'hF;
        o_word = '0;
        pend = '0;
        pend_v = 1'b0;
        in_wr = 1'b0;
    end
    // Presents one command just after an edge, holds it to the next edge
    task automatic step(input logic qn, input logic [2:0] sel,
        input logic wn, input logic adv, input logic [18:0] a,
        input logic [3:0] ln, input pbs_pkg::pbs_word_s w);
        o_qual_n = qn;
        o_sel = sel;
        o_write_n = wn;
        o_adv = adv;
        o_addr = a;
        o_lanes_n = ln;
        // Released lines toggle so a stale word never reads as valid
        o_word = pend_v ? pend : ~o_word;
        if (!qn) begin
            if (!adv) begin
                in_wr = (sel == 3'h2) && !wn;
            end
            pend_v = in_wr;
            pend = w;
        end
        @(posedge i_clk);
        #1;
    endtask
endmodule

// >>> sim/pbs_port_tb.sv
`timescale 1ns/1ps
module pbs_port_tb;
    logic clk, i_reset_n, i_mode, oe_n, qn, we_n, adv, q_rdy;
    logic [2:0] sel;
    logic [18:0] ha;
    logic [3:0] ln, o_par, o_par_oe_n, pin;
    logic [31:0] o_data, o_data_oe_n, din;
    pbs_pkg::pbs_word_s hw;
    logic [35:0] em [4096];
    int n_errors = 0;
    int n_tests = 0;
    // Wire level: whoever is enabled wins, the host drives otherwise
    assign din = (~o_data_oe_n & o_data) | (o_data_oe_n & hw.data);
    assign pin = (~o_par_oe_n & o_par) | (o_par_oe_n & hw.parity);
    pbs_host host (.i_clk(clk), .o_qual_n(qn), .o_sel(sel),
        .o_write_n(we_n), .o_adv(adv), .o_addr(ha), .o_lanes_n(ln),
        .o_word(hw));
    pbs_port dut (.i_core_clk(clk), .i_reset_n(i_reset_n),
        .i_mode(i_mode), .i_clk_qualify_n(qn),
        .i_chip_select_one_n(sel[2]), .i_chip_select_two(sel[1]),
        .i_chip_select_three_n(sel[0]), .i_write_n(we_n),
        .i_advance_or_load(adv), .i_addr(ha[18:2]),
        .i_burst_addr_bit_one(ha[1]), .i_burst_addr_bit_zero(ha[0]),
        .i_lane_write_sel_a_n(ln[0]), .i_lane_write_sel_b_n(ln[1]),
        .i_lane_write_sel_c_n(ln[2]), .i_lane_write_sel_d_n(ln[3]),
        .i_output_enable_n(oe_n), .i_data(din), .i_parity_lines(pin),
        .o_data(o_data), .o_data_oe_n(o_data_oe_n),
        .o_parity_lines(o_par), .o_parity_lines_oe_n(o_par_oe_n),
        .o_queue_ready(q_rdy));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    function automatic logic [35:0] pat(input int k);
        return {4'(k), 32'h1357_9BDF ^ (32'(k) * 32'h0101_0101)};
    endfunction
    task automatic rd(input logic [18:0] a);
        host.step(1'b0, 3'h2, 1'b1, 1'b0, a, 4'hF, '0);
    endtask
    task automatic nxt;
        host.step(1'b0, 3'h2, 1'b1, 1'b1, '0, 4'hF, '0);
    endtask
    task automatic desel;
        host.step(1'b0, 3'h5, 1'b1, 1'b0, '0, 4'hF, '0);
    endtask
    task automatic wr(input logic [18:0] a, input logic [3:0] l,
        input logic [35:0] w);
        logic [35:0] m;
        m = em[a[11:0]];
        for (int i = 0; i < 4; i++) begin
            if (!l[i]) begin
                m[8*i +: 8] = w[8*i +: 8];
                m[32+i] = w[32+i];
            end
        end
        em[a[11:0]] = m;
        host.step(1'b0, 3'h2, 1'b0, 1'b0, a, l, w);
    endtask
    // The read after a deselect run is a spare that no check looks at
    task automatic drain;
        repeat (20) desel();
        rd('0);
    endtask
    task automatic chkrd(input logic [18:0] a);
        chk(64'({o_par_oe_n, o_data_oe_n[0], o_par, o_data}),
            64'({5'h00, em[a[11:0]]}));
    endtask
    task automatic do_reset(input logic m);
        i_reset_n = 1'b0;
        i_mode = m;
        repeat (6) desel();
        chk(64'({q_rdy, o_par_oe_n, o_data_oe_n[0]}), 64'h1F);
        i_reset_n = 1'b1;
        repeat (6) desel();
    endtask
    task automatic t_lanes;
        wr(19'h00010, 4'h0, pat(1));
        wr(19'h00011, 4'h0, pat(2));
        wr(19'h00012, 4'h0, pat(3));
        wr(19'h00010, 4'hA, pat(9));
        wr(19'h00011, 4'hF, pat(7));
        drain();
        rd(19'h00010);
        rd(19'h00011);
        chkrd(19'h00010);
        rd(19'h00012);
        chkrd(19'h00011);
        nxt();
        chkrd(19'h00012);
        $display("t_lanes done");
    endtask
    task automatic t_oe;
        drain();
        oe_n = 1'b1;
        rd(19'h00010);
        nxt();
        chk(64'({o_par_oe_n, o_data_oe_n}), 64'hF_FFFF_FFFF);
        oe_n = 1'b0;
        nxt();
        chk(64'(o_data_oe_n[0]), 64'h0);
        wr(19'h00013, 4'h0, pat(4));
        chk(64'({o_par_oe_n, o_data_oe_n[0]}), 64'h1F);
        rd(19'h00010);
        chk(64'({o_par_oe_n, o_data_oe_n[0]}), 64'h1F);
        nxt();
        chkrd(19'h00010);
        $display("t_oe done");
    endtask
    task automatic t_sel;
        for (int c = 0; c < 8; c++) begin
            desel();
            desel();
            chk(64'({o_par_oe_n, o_data_oe_n[0]}), 64'h1F);
            host.step(1'b0, 3'(c), 1'b1, 1'b0, 19'h00010, 4'hF, '0);
            nxt();
            nxt();
            if (c == 2) begin
                chkrd(19'h00011);
            end else begin
                chk(64'({o_par_oe_n, o_data_oe_n[0]}), 64'h1F);
            end
        end
        $display("t_sel done");
    endtask
    task automatic t_freeze;
        drain();
        rd(19'h00010);
        rd(19'h00011);
        repeat (3) host.step(1'b1, 3'h5, 1'b0, 1'b0, 19'h00012, 4'h0,
            pat(5));
        chkrd(19'h00010);
        nxt();
        chkrd(19'h00011);
        drain();
        rd(19'h00012);
        nxt();
        chkrd(19'h00012);
        $display("t_freeze done");
    endtask
    // Reads stall the drain while writes keep arriving
    task automatic t_queue;
        for (int i = 0; i < 8; i++) begin
            wr(19'h00200 + 19'(i), 4'h0, pat(16 + i));
            rd(19'h00010);
            chk(64'(q_rdy), 64'h1);
        end
        drain();
        rd(19'h00200);
        for (int i = 1; i <= 8; i++) begin
            if (i < 8) begin
                rd(19'h00200 + 19'(i));
            end else begin
                nxt();
            end
            chkrd(19'h00200 + 19'(i - 1));
        end
        $display("t_queue done");
    endtask
    task automatic t_burst(input logic m);
        logic [18:0] ea;
        for (int k = 0; k < 4; k++) begin
            wr(19'h00100 + 19'(k), 4'h0, pat(32 + k + 4 * int'(m)));
        end
        drain();
        rd(19'h00101);
        for (int k = 0; k < 4; k++) begin
            nxt();
            ea = m ? 19'(1 ^ k) : 19'((1 + k) % 4);
            chkrd(19'h00100 + ea);
        end
        $display("t_burst done");
    endtask
    initial begin
        i_reset_n = 1'b0;
        i_mode = 1'b1;
        oe_n = 1'b0;
        @(posedge clk);
        #1;
        do_reset(1'b1);
        t_lanes();
        t_oe();
        t_sel();
        t_freeze();
        t_queue();
        t_burst(1'b1);
        do_reset(1'b0);
        t_burst(1'b0);
        give_verdict();
    end
    initial begin
        #(3000 * 25);
        n_errors++;
        give_verdict();
    end
endmodule
